// ---- rtl/sbc_ctrl.sv ----
// control/status and data registers with the bit engine of the two-wire bus
`timescale 1ns/1ns
module sbc_ctrl (
    // system side
    input wire logic ref_clk,
    input wire logic rst_b,
    // special-function-register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    // link side, open drain pins
    input wire logic linkClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    typedef enum logic [2:0] {
        L_IDLE, L_START, L_LOW, L_HIGH, L_HOLD, L_STOP1, L_STOP2, L_STOP3
    } sbc_lst_t;

    // ---------------- system clock domain ----------------
    logic master, transmitter_role_flag, beginFlag, haltFlag, respNeeded, lossFlag, handFlag, eventFlag;
    logic [7:0] dataReg;
    logic dataWritten, reqTog, cmdSta, cmdSto, cmdAck, cmdTx;
    logic [7:0] cmdData;
    logic next_master, next_transmitter_role_flag, next_beginFlag, next_haltFlag, next_respNeeded;
    logic next_lossFlag, next_handFlag, next_eventFlag, next_dataWritten, next_reqTog;
    logic next_cmdSta, next_cmdSto, next_cmdAck, next_cmdTx;
    logic [7:0] next_dataReg, next_cmdData, next_rd;
    logic ackS1, ackS2, evS1, evS2, evS3;
    logic goPend, go;
    // link-domain registers read here only behind the event toggle
    logic evTog, evAck;
    sbc_pkg::sbc_ev_t evCode;
    logic [7:0] evByte;
    logic ackTog;

    always_ff @(posedge ref_clk) begin
        ackS1 <= ackTog;
        ackS2 <= ackS1;
        evS1 <= evTog;
        evS2 <= evS1;
        evS3 <= evS2;
    end

    always_comb begin
        next_master = master;
        next_transmitter_role_flag = transmitter_role_flag;
        next_beginFlag = beginFlag;
        next_haltFlag = haltFlag;
        next_respNeeded = respNeeded;
        next_lossFlag = lossFlag;
        next_handFlag = handFlag;
        next_eventFlag = eventFlag;
        next_dataReg = dataReg;
        next_dataWritten = dataWritten;
        next_reqTog = reqTog;
        next_cmdSta = cmdSta;
        next_cmdSto = cmdSto;
        next_cmdAck = cmdAck;
        next_cmdTx = cmdTx;
        next_cmdData = cmdData;
        goPend = reqTog != ackS2;
        go = 1'b0;
        if (sfrWrEn && sfrAddr == sbc_pkg::CTRL_ADDR) begin
            // role, response and loss bits take no write data; an event clear zeroes loss and response and sets the role from dataWritten
            next_beginFlag = sfrWrData[sbc_pkg::BEGIN_BIT];
            next_haltFlag = sfrWrData[sbc_pkg::HALT_BIT];
            next_handFlag = sfrWrData[sbc_pkg::HAND_BIT];
            if (eventFlag && !sfrWrData[sbc_pkg::EVENT_BIT]) begin
                next_eventFlag = 1'b0;
                next_lossFlag = 1'b0;
                next_respNeeded = 1'b0;
                next_transmitter_role_flag = dataWritten;
                go = 1'b1;
            end else if (!eventFlag && !master && !beginFlag
                         && sfrWrData[sbc_pkg::BEGIN_BIT]) begin
                go = 1'b1;
            end
        end
        if (sfrWrEn && sfrAddr == sbc_pkg::DATA_ADDR) begin
            next_dataReg = sfrWrData;
            next_dataWritten = 1'b1;
        end
        // a second request while one is in flight cannot be honoured and is dropped
        if (go && !goPend) begin
            next_reqTog = !reqTog;
            next_cmdSta = next_beginFlag;
            next_cmdSto = next_haltFlag;
            next_cmdAck = next_handFlag;
            next_cmdTx = next_dataWritten;
            next_cmdData = next_dataReg;
            next_dataWritten = 1'b0;
        end
        // link events come last so they beat a same-cycle register write
        if (evS2 != evS3) begin
            next_eventFlag = evCode != sbc_pkg::EV_STOP_GEN;
            case (evCode)
                sbc_pkg::EV_START_GEN: begin
                    next_master = 1'b1;
                    next_transmitter_role_flag = 1'b1;
                end
                sbc_pkg::EV_ARB, sbc_pkg::EV_ARB_STOP: begin
                    next_master = 1'b0;
                    next_transmitter_role_flag = 1'b0;
                    next_lossFlag = 1'b1;
                    next_dataReg = evByte;
                    if (evCode == sbc_pkg::EV_ARB_STOP) begin
                        next_haltFlag = 1'b1;
                    end
                end
                sbc_pkg::EV_TX_DONE: begin
                    next_handFlag = !evAck;
                    next_dataReg = evByte;
                end
                sbc_pkg::EV_RX_BYTE: begin
                    next_respNeeded = 1'b1;
                    next_handFlag = 1'b0;
                    next_dataReg = evByte;
                end
                sbc_pkg::EV_ADDR_RX: begin
                    next_beginFlag = 1'b1;
                    next_transmitter_role_flag = 1'b0;
                    next_respNeeded = 1'b1;
                    next_handFlag = 1'b0;
                    next_dataReg = evByte;
                end
                sbc_pkg::EV_STOP_RX: begin
                    next_haltFlag = 1'b1;
                end
                sbc_pkg::EV_STOP_GEN: begin
                    next_haltFlag = 1'b0;
                    next_master = 1'b0;
                end
                default: begin
                end
            endcase
        end
        case (sfrAddr)
            sbc_pkg::CTRL_ADDR: next_rd = {master, transmitter_role_flag, beginFlag, haltFlag,
                                           respNeeded, lossFlag, handFlag, eventFlag};
            sbc_pkg::DATA_ADDR: next_rd = dataReg;
            default: next_rd = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {master, transmitter_role_flag, beginFlag, haltFlag, respNeeded, lossFlag, handFlag, eventFlag}
                <= sbc_pkg::CTRL_RESET;
            dataReg <= sbc_pkg::DATA_RESET;
            dataWritten <= 1'b0;
            reqTog <= 1'b0;
            cmdSta <= 1'b0;
            cmdSto <= 1'b0;
            cmdAck <= 1'b0;
            cmdTx <= 1'b0;
            cmdData <= sbc_pkg::DATA_RESET;
            sfrRdData <= 8'h00;
        end else begin
            master <= next_master;
            transmitter_role_flag <= next_transmitter_role_flag;
            beginFlag <= next_beginFlag;
            haltFlag <= next_haltFlag;
            respNeeded <= next_respNeeded;
            lossFlag <= next_lossFlag;
            handFlag <= next_handFlag;
            eventFlag <= next_eventFlag;
            dataReg <= next_dataReg;
            dataWritten <= next_dataWritten;
            reqTog <= next_reqTog;
            cmdSta <= next_cmdSta;
            cmdSto <= next_cmdSto;
            cmdAck <= next_cmdAck;
            cmdTx <= next_cmdTx;
            cmdData <= next_cmdData;
            sfrRdData <= next_rd;
        end
    end

    // ---------------- link clock domain ----------------
    logic lrst1, lrst2, req1, req2, scl1, sclH, sda1, sdaH, sclPrev, sdaPrev;
    localparam int TMR_W = sbc_pkg::TMR_W;
    sbc_lst_t lst, next_lst;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [3:0] bitIdx, next_bitIdx;
    logic [7:0] shReg, next_shReg, next_evByte;
    logic lMaster, lTx, lSta, lSto, isAddr, sampled, arbPend, addressed, rsMode;
    logic busBusy, startPend, holdRx, sclDrv, sdaDrv;
    logic next_lMaster, next_lTx, next_lSta, next_lSto, next_isAddr, next_sampled;
    logic next_arbPend, next_addressed, next_rsMode, next_busBusy, next_startPend;
    logic next_holdRx, next_sclDrv, next_sdaDrv, next_ackTog, next_evTog, next_evAck;
    sbc_pkg::sbc_ev_t next_evCode;
    logic startSeen, stopSeen, goNew;

    // pins and the system reset pass two flops before use
    always_ff @(posedge linkClk) begin
        lrst1 <= rst_b;
        lrst2 <= lrst1;
        req1 <= reqTog;
        req2 <= req1;
        scl1 <= sclIn;
        sclH <= scl1;
        sda1 <= sdaIn;
        sdaH <= sda1;
    end

    always_comb begin
        next_lst = lst;
        next_tmr = tmr;
        next_bitIdx = bitIdx;
        next_shReg = shReg;
        {next_lMaster, next_lTx, next_lSta, next_lSto} = {lMaster, lTx, lSta, lSto};
        {next_isAddr, next_sampled, next_arbPend, next_addressed} =
            {isAddr, sampled, arbPend, addressed};
        {next_rsMode, next_startPend, next_holdRx} = {rsMode, startPend, holdRx};
        {next_sclDrv, next_sdaDrv, next_ackTog} = {sclDrv, sdaDrv, ackTog};
        {next_evTog, next_evAck, next_evCode, next_evByte} = {evTog, evAck, evCode, evByte};
        startSeen = sclH && sclPrev && sdaPrev && !sdaH;
        stopSeen = sclH && sclPrev && !sdaPrev && sdaH;
        goNew = req2 != ackTog;
        next_busBusy = startSeen ? 1'b1 : (stopSeen ? 1'b0 : busBusy);
        if (goNew && (lst == L_IDLE || lst == L_HOLD)) begin
            next_ackTog = req2;
            {next_lSta, next_lSto, next_lTx} = {cmdSta, cmdSto, cmdTx};
            next_shReg = cmdData;
            next_tmr = '0;
        end
        case (lst)
            L_IDLE: begin
                {next_sclDrv, next_sdaDrv} = 2'b00;
                if (goNew && cmdSta) begin
                    next_startPend = 1'b1;
                end
                if (startSeen) begin
                    {next_lMaster, next_lTx, next_isAddr, next_addressed} = 4'b0010;
                    {next_bitIdx, next_sampled} = {4'd0, 1'b0};
                    next_lst = L_LOW;
                end else if (startPend && !busBusy) begin
                    next_sdaDrv = 1'b1;
                    next_startPend = 1'b0;
                    next_tmr = '0;
                    next_lst = L_START;
                end
            end
            L_START: begin
                next_tmr = tmr + 1'b1;
                if (tmr >= sbc_pkg::SCL_HIGH_CYC) begin
                    {next_sclDrv, next_lMaster, next_lTx, next_holdRx} = 4'b1110;
                    {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_START_GEN};
                    next_lst = L_HOLD;
                end
            end
            L_LOW: begin
                if (lMaster) begin
                    next_tmr = tmr + 1'b1;
                    if (tmr >= sbc_pkg::SCL_LOW_CYC) begin
                        {next_sclDrv, next_tmr, next_lst} = {1'b0, TMR_W'(0), L_HIGH};
                    end
                end else if (sclH) begin
                    {next_tmr, next_lst} = {TMR_W'(0), L_HIGH};
                end
            end
            L_HIGH: begin
                if (sclH) begin
                    next_tmr = tmr + 1'b1;
                end
                if (sclH && !sampled) begin
                    next_sampled = 1'b1;
                    if (bitIdx < 4'd8) begin
                        next_shReg = {shReg[6:0], sdaH};
                        if (lTx && !sdaDrv && !sdaH) begin
                            // fall back to slave receiver, byte keeps shifting in
                            {next_lMaster, next_lTx, next_sdaDrv, next_arbPend} = 4'b0001;
                        end
                    end else begin
                        next_evAck = sdaH;
                    end
                end
                if (stopSeen) begin
                    {next_sclDrv, next_sdaDrv} = 2'b00;
                    if (lMaster) begin
                        {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_ARB_STOP};
                        next_lMaster = 1'b0;
                    end else if (addressed) begin
                        {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_STOP_RX};
                    end
                    next_lst = L_IDLE;
                end else if (startSeen) begin
                    if (lMaster) begin
                        // repeated start nobody here asked for
                        {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_ARB};
                        next_evByte = shReg;
                    end
                    {next_lMaster, next_lTx, next_isAddr, next_addressed} = 4'b0010;
                    {next_sclDrv, next_sdaDrv, next_sampled, next_bitIdx} = {3'b000, 4'd0};
                    next_lst = L_LOW;
                end else if (sampled && ((lMaster && tmr >= sbc_pkg::SCL_HIGH_CYC)
                                         || (!lMaster && !sclH))) begin
                    {next_sclDrv, next_sampled, next_tmr} = {lMaster, 1'b0, TMR_W'(0)};
                    next_lst = L_LOW;
                    next_sdaDrv = 1'b0;
                    next_evByte = shReg;
                    if (bitIdx < 4'd7) begin
                        next_bitIdx = bitIdx + 4'd1;
                        next_sdaDrv = lTx && !shReg[7];
                    end else if (bitIdx == 4'd7 && (arbPend || !lTx)) begin
                        // receiver reports before its acknowledge bit
                        next_evTog = !evTog;
                        next_evCode = arbPend ? sbc_pkg::EV_ARB
                                    : (isAddr ? sbc_pkg::EV_ADDR_RX : sbc_pkg::EV_RX_BYTE);
                        {next_arbPend, next_sclDrv, next_holdRx, next_lst} = {3'b011, L_HOLD};
                    end else if (bitIdx == 4'd7) begin
                        next_bitIdx = 4'd8;
                    end else if (lTx) begin
                        // transmitter reports after the acknowledge bit
                        {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_TX_DONE};
                        {next_sclDrv, next_holdRx, next_lst} = {2'b10, L_HOLD};
                    end else if (isAddr && !lSta && !addressed) begin
                        next_lst = L_IDLE;
                    end else if (lMaster && (lSto || lSta)) begin
                        {next_rsMode, next_sclDrv, next_lst} = {!lSto, 1'b1, L_STOP1};
                    end else begin
                        {next_bitIdx, next_isAddr} = {4'd0, 1'b0};
                        next_sdaDrv = lTx && !shReg[7];
                    end
                end
            end
            L_HOLD: begin
                next_sclDrv = 1'b1;
                if (goNew) begin
                    if (holdRx) begin
                        // acknowledge level as software left it
                        {next_bitIdx, next_sdaDrv, next_sclDrv} = {4'd8, cmdAck, lMaster};
                        next_addressed = addressed || (isAddr && cmdAck);
                        next_lTx = 1'b0;
                        next_lst = L_LOW;
                    end else if (lMaster && (cmdSto || cmdSta)) begin
                        {next_rsMode, next_lst} = {!cmdSto, L_STOP1};
                    end else begin
                        {next_bitIdx, next_isAddr, next_sclDrv} = {4'd0, 1'b0, lMaster};
                        next_sdaDrv = cmdTx && !cmdData[7];
                        next_lst = L_LOW;
                    end
                end
            end
            L_STOP1: begin
                next_sdaDrv = !rsMode;
                next_tmr = tmr + 1'b1;
                if (tmr >= sbc_pkg::SCL_LOW_CYC) begin
                    {next_sclDrv, next_tmr, next_lst} = {1'b0, TMR_W'(0), L_STOP2};
                end
            end
            L_STOP2: begin
                next_tmr = tmr + 1'b1;
                if (tmr >= sbc_pkg::SCL_HIGH_CYC && !sclH) begin
                    {next_evTog, next_evCode, next_evByte} = {!evTog, sbc_pkg::EV_ARB, shReg};
                    {next_lMaster, next_sdaDrv, next_lst} = {2'b00, L_IDLE};
                end else if (tmr >= sbc_pkg::SCL_HIGH_CYC) begin
                    {next_sdaDrv, next_tmr} = {rsMode, TMR_W'(0)};
                    next_lst = rsMode ? L_START : L_STOP3;
                end
            end
            L_STOP3: begin
                next_tmr = tmr + 1'b1;
                if (tmr >= sbc_pkg::SCL_HIGH_CYC) begin
                    {next_evTog, next_evCode} = {!evTog, sbc_pkg::EV_STOP_GEN};
                    {next_lMaster, next_startPend, next_lst} = {1'b0, lSta, L_IDLE};
                end
            end
            default: next_lst = L_IDLE;
        endcase
    end

    always_ff @(posedge linkClk) begin
        if (!lrst2) begin
            {lst, tmr, bitIdx, shReg} <= {L_IDLE, TMR_W'(0), 4'd0, 8'h00};
            {lMaster, lTx, lSta, lSto, isAddr, sampled, arbPend, addressed} <= 8'h00;
            {rsMode, busBusy, startPend, holdRx, sclDrv, sdaDrv, ackTog} <= 7'h00;
            {evTog, evAck, evCode, evByte} <= {2'b00, sbc_pkg::EV_START_GEN, 8'h00};
            // pin data stays low in reset too: open drain never drives high
            {sclPrev, sdaPrev, sclOut, sdaOut} <= 4'hC;
        end else begin
            {lst, tmr, bitIdx, shReg} <= {next_lst, next_tmr, next_bitIdx, next_shReg};
            {lMaster, lTx, lSta, lSto} <= {next_lMaster, next_lTx, next_lSta, next_lSto};
            {isAddr, sampled, arbPend, addressed} <=
                {next_isAddr, next_sampled, next_arbPend, next_addressed};
            {rsMode, busBusy, startPend, holdRx} <=
                {next_rsMode, next_busBusy, next_startPend, next_holdRx};
            {sclDrv, sdaDrv, ackTog} <= {next_sclDrv, next_sdaDrv, next_ackTog};
            {evTog, evAck, evCode, evByte} <= {next_evTog, next_evAck, next_evCode, next_evByte};
            {sclPrev, sdaPrev} <= {sclH, sdaH};
            {sclOut, sdaOut} <= 2'b00;
        end
    end

    assign sclOe = sclDrv;
    assign sdaOe = sdaDrv;
endmodule : sbc_ctrl

// ---- rtl/sbc_pkg.sv ----
// shared constants and types of the two-wire bus control and data registers
package sbc_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'hC0;
    localparam logic [7:0] DATA_ADDR = 8'hC2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int MASTER_BIT = 7;
    localparam int TX_BIT = 6;
    localparam int BEGIN_BIT = 5;
    localparam int HALT_BIT = 4;
    localparam int RESP_BIT = 3;
    localparam int LOSS_BIT = 2;
    localparam int HAND_BIT = 1;
    localparam int EVENT_BIT = 0;
    localparam int LINK_CLK_NS = 12;
    localparam int SCL_LOW_NS = 4700;
    localparam int SCL_HIGH_NS = 4000;
    localparam int TMR_W = 10;

    function automatic int ceil_cycles(input int ns, input int period);
        ceil_cycles = (ns + period - 1) / period;
    endfunction : ceil_cycles

    localparam logic [TMR_W-1:0] SCL_LOW_CYC = TMR_W'(ceil_cycles(SCL_LOW_NS, LINK_CLK_NS));
    localparam logic [TMR_W-1:0] SCL_HIGH_CYC = TMR_W'(ceil_cycles(SCL_HIGH_NS, LINK_CLK_NS));

    typedef enum logic [2:0] {
        EV_START_GEN,
        EV_ARB,
        EV_ARB_STOP,
        EV_TX_DONE,
        EV_RX_BYTE,
        EV_ADDR_RX,
        EV_STOP_RX,
        EV_STOP_GEN
    } sbc_ev_t;
endpackage : sbc_pkg

// ---- verif/sbc_bus_slave.sv ----
// behavioural bus target: acknowledges writes, returns txByte on every read byte until the master nacks
`timescale 1ns/1ns
module sbc_bus_slave (
    // bus wires
    input wire logic scl,
    input wire logic sda,
    // byte returned on reads
    input wire logic [7:0] txByte,
    // high pulls sda low
    output logic sdaPull
);
    int bitCnt = 0;
    logic [7:0] shiftIn = 8'h00;
    logic reading = 1'b0;
    logic addrPhase = 1'b0;
    initial sdaPull = 1'b0;
    always @(negedge sda) begin
        if (scl) begin
            bitCnt = -1;
            addrPhase = 1'b1;
            reading = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (bitCnt < 8) shiftIn = {shiftIn[6:0], sda};
        else if (reading && sda) reading = 1'b0; // nack from master ends the read
    end
    always @(negedge scl) begin
        bitCnt = bitCnt + 1;
        if (bitCnt == 9) begin
            bitCnt = 0;
            if (addrPhase) reading = shiftIn[0];
            addrPhase = 1'b0;
        end
        sdaPull = (bitCnt == 8) ? !reading : reading && !txByte[7 - bitCnt];
    end
endmodule : sbc_bus_slave

// ---- verif/sbc_ctrl_properties.sv ----
// concurrent checks on the register port and the open-drain pins
`timescale 1ns/1ns
module sbc_ctrl_properties (
    // system side
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] sfrRdData,
    // pins
    input wire logic sclIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] prevAddr;
    logic prevWr;
    logic onCtrl;
    logic held;
    // read data lags the address by one edge, so track what it shows
    always_ff @(posedge ref_clk) begin
        prevAddr <= sfrAddr;
        prevWr <= sfrWrEn;
    end
    assign onCtrl = sfrAddr == sbc_pkg::CTRL_ADDR;
    assign held = prevAddr == sbc_pkg::CTRL_ADDR;
    sequence clr_event;
        sfrWrEn && onCtrl && !sfrWrData[sbc_pkg::EVENT_BIT] ##1 onCtrl;
    endsequence
    sequence ctrl_write;
        sfrWrEn && onCtrl ##1 onCtrl;
    endsequence
    open_drain_a: assert property (!sclOut && !sdaOut) else $error("pin level not low");
    unmapped_zero_a: assert property (!onCtrl && sfrAddr != sbc_pkg::DATA_ADDR |=>
        sfrRdData == 8'h00) else $error("unmapped read not zero");
    loss_clear_a: assert property (clr_event |=> !sfrRdData[sbc_pkg::LOSS_BIT]
        && !sfrRdData[sbc_pkg::EVENT_BIT]) else $error("loss or event not cleared");
    master_ro_a: assert property (ctrl_write |=> sfrRdData[sbc_pkg::MASTER_BIT] ==
        $past(sfrRdData[sbc_pkg::MASTER_BIT])) else $error("role flag written");
    begin_kept_a: assert property (held && onCtrl && !prevWr &&
        sfrRdData[sbc_pkg::BEGIN_BIT] |=> sfrRdData[sbc_pkg::BEGIN_BIT]) else $error("begin lost");
    nack_default_a: assert property (held && $past(held) &&
        $rose(sfrRdData[sbc_pkg::RESP_BIT]) |-> !sfrRdData[sbc_pkg::HAND_BIT]) else $error("no nack");
    stall_hold_a: assert property (held && sfrRdData[sbc_pkg::EVENT_BIT] &&
        sfrRdData[sbc_pkg::MASTER_BIT] |-> sclOe) else $error("clock not held low");
    halt_done_a: assert property ($fell(sdaOe) && !sclOe && sclIn |-> ##[1:1000]
        (!held || !sfrRdData[sbc_pkg::HALT_BIT] && !sfrRdData[sbc_pkg::MASTER_BIT]))
        else $error("halt not cleared");
endmodule : sbc_ctrl_properties
bind sbc_ctrl sbc_ctrl_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ---- verif/tb_sbc_ctrl.sv ----
// self-checking bench: register port, a master address write and a master read
`timescale 1ns/1ns
module tb_sbc_ctrl;
    logic ref_clk = 1'b0;
    logic linkClk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrEn = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData, txByte;
    logic sclOe, sdaOe, sdaPull;
    int seed = 32'h1AA2D34E;
    int mismatches = 0;
    int checks = 0;
    int busQ[$];
    wire logic sclW = !sclOe;
    wire logic sdaW = !(sdaOe || sdaPull);
    sbc_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .linkClk(linkClk), .sclIn(sclW),
        .sdaIn(sdaW), .sclOut(), .sclOe(sclOe), .sdaOut(), .sdaOe(sdaOe));
    sbc_bus_slave target (.scl(sclW), .sda(sdaW), .txByte(txByte), .sdaPull(sdaPull));
    initial begin
        forever #4 ref_clk = !ref_clk;
    end
    initial begin
        #3;
        forever #6 linkClk = !linkClk;
    end
    function automatic logic [7:0] cv(input int m, t, b, h, r, a, e);
        return 8'((m << 7) | (t << 6) | (b << 5) | (h << 4) | (r << 3) | (a << 1) | e);
    endfunction : cv
    task automatic close_out();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge ref_clk);
        sfrWrEn = 1'b0;
        @(negedge ref_clk);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        sfrAddr = a;
        @(negedge ref_clk);
        checks++;
        if (sfrRdData !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, sfrRdData);
        end
    endtask : rd_chk
    // bounded poll of one control bit; a hang here counts as a mismatch
    task automatic wait_ctrl(input int idx, input logic val);
        int n;
        sfrAddr = sbc_pkg::CTRL_ADDR;
        repeat (2) @(negedge ref_clk);
        for (n = 0; n < 30000 && sfrRdData[idx] !== val; n++) @(negedge ref_clk);
        if (n == 30000) begin
            mismatches++;
            $display("Error ctrl bit %0d expected %b seen %b", idx, val, sfrRdData[idx]);
        end
    endtask : wait_ctrl
    initial begin
        txByte = 8'($random(seed));
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
        rd_chk(sbc_pkg::CTRL_ADDR, sbc_pkg::CTRL_RESET, "ctrl reset");
        wr(sbc_pkg::CTRL_ADDR, 8'hCF);
        wr(8'hC1, 8'hFF);
        rd_chk(8'hC1, 8'h00, "unmapped");
        rd_chk(sbc_pkg::CTRL_ADDR, cv(0, 0, 0, 0, 0, 1, 0), "ctrl ro");
        wr(sbc_pkg::CTRL_ADDR, 8'h20);
        wait_ctrl(sbc_pkg::EVENT_BIT, 1'b1);
        rd_chk(sbc_pkg::CTRL_ADDR, cv(1, 1, 1, 0, 0, 0, 1), "start");
        busQ.push_back(($random(seed) & 8'hFE) | 1);
        wr(sbc_pkg::DATA_ADDR, 8'(busQ[0]));
        wr(sbc_pkg::CTRL_ADDR, 8'h00);
        wait_ctrl(sbc_pkg::EVENT_BIT, 1'b1);
        rd_chk(sbc_pkg::CTRL_ADDR, cv(1, 1, 0, 0, 0, 1, 1), "tx ack");
        rd_chk(sbc_pkg::DATA_ADDR, 8'(busQ.pop_front()), "tx byte");
        busQ.push_back(txByte);
        wr(sbc_pkg::CTRL_ADDR, 8'h00);
        wait_ctrl(sbc_pkg::EVENT_BIT, 1'b1);
        rd_chk(sbc_pkg::CTRL_ADDR, cv(1, 0, 0, 0, 1, 0, 1), "rx");
        rd_chk(sbc_pkg::DATA_ADDR, 8'(busQ.pop_front()), "rx byte");
        wr(sbc_pkg::CTRL_ADDR, 8'h10);
        rd_chk(sbc_pkg::CTRL_ADDR, cv(1, 0, 0, 1, 0, 0, 0), "halt pending");
        wait_ctrl(sbc_pkg::MASTER_BIT, 1'b0);
        rd_chk(sbc_pkg::CTRL_ADDR, 8'h00, "after stop");
        close_out();
    end
    initial begin
        #(8 * 60000);
        mismatches++;
        $display("Error watchdog expected done seen hang");
        close_out();
    end
endmodule : tb_sbc_ctrl
